// file: verilog/ssr_defs.svh
// Register offsets, field positions, reset values and timing counts of the serial port block
`ifndef SSR_DEFS_SVH
`define SSR_DEFS_SVH

`define SSR_ADDR_W 7
`define SSR_DATA_W 8
`define SSR_CMD_BITS 5'h10
`define SSR_ADDR_DONE 5'h07
`define SSR_RD_FIRST 5'h08
`define SSR_RD_LAST 5'h0E

`define SSR_OFF_EXP_SEL 7'h28
`define SSR_OFF_EXP_T0 7'h29
`define SSR_OFF_EXP_T1 7'h2A
`define SSR_OFF_EXP_T2 7'h2B
`define SSR_OFF_FRAMES_LO 7'h36
`define SSR_OFF_FRAMES_HI 7'h37
`define SSR_OFF_IMM_LO 7'h38
`define SSR_OFF_IMM_HI 7'h39
`define SSR_OFF_TEMP_LO 7'h58
`define SSR_OFF_TEMP_HI 7'h59
`define SSR_OFF_STATUS 7'h5A
`define SSR_OFF_CLK_GATE 7'h7B

`define SSR_BIT_EXT 0
`define SSR_BIT_GATE 0
`define SSR_REG_RESET 8'h00

`define SSR_CLK_MHZ 20
`define SSR_EXP_TICK_NS 1000
`define SSR_EXP_TICK_CYC ((`SSR_EXP_TICK_NS * `SSR_CLK_MHZ) / 1000)
`define SSR_FOT_NS 2000
`define SSR_FOT_CYC ((`SSR_FOT_NS * `SSR_CLK_MHZ) / 1000)
`define SSR_READOUT_NS 20000
`define SSR_READOUT_CYC ((`SSR_READOUT_NS * `SSR_CLK_MHZ) / 1000)

`endif

// file: verilog/ssr_pkg.sv
// Types shared by the serial port block
package ssr_pkg;
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_EXPOSE = 2'b01,
    SEQ_FOT = 2'b10,
    SEQ_READOUT = 2'b11
  } ssr_seq_state_t;
endpackage : ssr_pkg

// file: verilog/ssr_sync.sv
// Three-stage input synchroniser; a change counts once stages two and three agree
`timescale 1ns/10ps
module ssr_sync #(
  parameter int W = 1
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_level
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  wire [W-1:0] agree = ~(s2_r ^ s3_r);

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      o_level <= '0;
    end else begin
      s1_r <= i_async;
      s2_r <= s1_r;
      s3_r <= s2_r;
      o_level <= (agree & s3_r) | (~agree & o_level);
    end
  end
endmodule : ssr_sync

// file: verilog/ssr_top.sv
// Serial register port, register file and exposure sequencer of the image sensor
//
// Contract
// - Command is one control bit, 7-bit address, then 8 data bits.
// - Read data is driven right after the address LSB arrives.
// - Read data leaves on the serial output MSB first.
// - Input bits are captured on the rising serial clock edge.
// - Select held high allows back-to-back commands in one burst.
// - Registers 56 and 57 may be written at any time, act at once.
// - Registers 88, 89, 90 are read-only; writes to them are dropped.
// - Registers 88 and 89 show the 16-bit temperature value.
// - System reset returns every programmable register to its default.
// - Register 40 bit 0 selects internal (0) or external (1) exposure.
// - Registers 54 and 55 hold frames produced per request internally.
// - Internal mode: request only starts exposure; sensor times the rest.
// - External mode: pins start exposure and read-out; sensor times read-out.
// - Internal mode: exposure starts on request, counts down, then overhead.
`timescale 1ns/10ps
`include "ssr_defs.svh"
module ssr_top #(
  parameter int EXP_TICK_CYC = `SSR_EXP_TICK_CYC,
  parameter int FOT_CYC = `SSR_FOT_CYC,
  parameter int READOUT_CYC = `SSR_READOUT_CYC
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_spi_en,
  input wire logic i_spi_clk,
  input wire logic i_spi_in,
  output logic o_spi_out,
  input wire logic i_frame_req,
  input wire logic i_int_req,
  input wire logic [15:0] i_temperature,
  output logic o_exposing,
  output logic o_frame_overhead_time,
  output logic o_readout,
  output logic o_clock_gated,
  output logic [7:0] o_imm_ctrl
);
  // Pin synchronisers
  logic [4:0] pins_lv;
  ssr_sync #(.W(5)) u_sync (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_async({i_int_req, i_frame_req, i_spi_in, i_spi_clk, i_spi_en}),
    .o_level(pins_lv)
  );
  wire en_lv = pins_lv[0];
  wire sclk_lv = pins_lv[1];
  wire sdi_lv = pins_lv[2];
  wire req_lv = pins_lv[3];
  wire int_lv = pins_lv[4];

  logic sclk_d_r;
  logic req_d_r;
  logic int_d_r;
  wire sclk_rise = sclk_lv & ~sclk_d_r;
  wire sclk_fall = ~sclk_lv & sclk_d_r;
  wire req_rise = req_lv & ~req_d_r;
  wire int_rise = int_lv & ~int_d_r;

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      sclk_d_r <= 1'b0;
      req_d_r <= 1'b0;
      int_d_r <= 1'b0;
    end else begin
      sclk_d_r <= sclk_lv;
      req_d_r <= req_lv;
      int_d_r <= int_lv;
    end
  end

  function automatic logic is_read_only(input logic [6:0] a);
    return (a == `SSR_OFF_TEMP_LO) || (a == `SSR_OFF_TEMP_HI) || (a == `SSR_OFF_STATUS);
  endfunction : is_read_only

  // Serial command engine
  logic [4:0] bit_cnt_r;
  logic is_wr_r;
  logic [6:0] addr_r;
  logic [7:0] wdata_r;
  logic [7:0] rd_sh_r;
  logic [7:0] mem_r [0:127];
  ssr_pkg::ssr_seq_state_t state_r;

  wire [6:0] addr_full = {addr_r[5:0], sdi_lv};
  wire in_ctrl = (bit_cnt_r == 5'h00);
  wire in_addr = (bit_cnt_r != 5'h00) && (bit_cnt_r <= `SSR_ADDR_DONE);
  wire addr_last = sclk_rise && (bit_cnt_r == `SSR_ADDR_DONE) && !is_wr_r;
  // Shift on the seen rise: sync lag would push a falling-edge shift past the host's next rise
  wire rd_shift = sclk_rise && !is_wr_r && (bit_cnt_r >= `SSR_RD_FIRST)
    && (bit_cnt_r <= `SSR_RD_LAST);
  wire cmd_end = sclk_fall && (bit_cnt_r == `SSR_CMD_BITS);
  wire wr_en = cmd_end && is_wr_r && !is_read_only(addr_r);
  wire [7:0] status_byte = {6'h00, state_r};
  wire [7:0] rd_value =
    (addr_full == `SSR_OFF_TEMP_LO) ? i_temperature[7:0] :
    (addr_full == `SSR_OFF_TEMP_HI) ? i_temperature[15:8] :
    (addr_full == `SSR_OFF_STATUS) ? status_byte : mem_r[addr_full];

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      bit_cnt_r <= 5'h00;
      is_wr_r <= 1'b0;
      addr_r <= 7'h00;
      wdata_r <= 8'h00;
    end else if (!en_lv) begin
      bit_cnt_r <= 5'h00;
    end else if (sclk_rise && bit_cnt_r < `SSR_CMD_BITS) begin
      bit_cnt_r <= bit_cnt_r + 5'h01;
      if (in_ctrl) begin
        is_wr_r <= sdi_lv;
      end else if (in_addr) begin
        addr_r <= addr_full;
      end else begin
        wdata_r <= {wdata_r[6:0], sdi_lv};
      end
    end else if (cmd_end) begin
      bit_cnt_r <= 5'h00;
    end
  end

  // Read data: MSB appears right after the address LSB, rest on later rising edges
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      rd_sh_r <= 8'h00;
      o_spi_out <= 1'b0;
    end else if (addr_last) begin
      rd_sh_r <= rd_value;
      o_spi_out <= rd_value[7];
    end else if (rd_shift) begin
      rd_sh_r <= {rd_sh_r[6:0], 1'b0};
      o_spi_out <= rd_sh_r[6];
    end
  end

  // Register file; writes commit on the final falling edge
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      for (int i = 0; i < 128; i++) begin
        mem_r[i] <= `SSR_REG_RESET;
      end
    end else if (wr_en) begin
      mem_r[addr_r] <= wdata_r;
    end
  end

  wire ext_mode = mem_r[`SSR_OFF_EXP_SEL][`SSR_BIT_EXT];
  wire gate = mem_r[`SSR_OFF_CLK_GATE][`SSR_BIT_GATE];
  wire [15:0] frames_cfg = {mem_r[`SSR_OFF_FRAMES_HI], mem_r[`SSR_OFF_FRAMES_LO]};
  wire [23:0] exp_cfg = {mem_r[`SSR_OFF_EXP_T2], mem_r[`SSR_OFF_EXP_T1],
    mem_r[`SSR_OFF_EXP_T0]};
  // Immediate-class pair drives o_imm_ctrl (XOR of the two) without waiting for idle
  assign o_imm_ctrl = mem_r[`SSR_OFF_IMM_LO] ^ mem_r[`SSR_OFF_IMM_HI];
  assign o_clock_gated = gate;

  // Exposure tick divider; held at zero while the core clock is gated
  logic [15:0] tick_cnt_r;
  wire tick = (tick_cnt_r == 16'(EXP_TICK_CYC - 1));
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      tick_cnt_r <= 16'h0000;
    end else if (gate || tick || state_r != ssr_pkg::SEQ_EXPOSE) begin
      tick_cnt_r <= 16'h0000;
    end else begin
      tick_cnt_r <= tick_cnt_r + 16'h0001;
    end
  end

  // Sequencer
  logic [23:0] seq_cnt_r;
  logic [23:0] seq_cnt_nxt;
  logic [15:0] frames_left_r;
  logic [15:0] frames_left_nxt;
  ssr_pkg::ssr_seq_state_t state_nxt;
  wire readout_done = (seq_cnt_r == 24'h000000);
  wire [15:0] frames_req = (frames_cfg == 16'h0000) ? 16'h0001 : frames_cfg;

  always_comb begin
    state_nxt = state_r;
    seq_cnt_nxt = seq_cnt_r;
    frames_left_nxt = frames_left_r;
    if (!gate) begin
      case (state_r)
        ssr_pkg::SEQ_IDLE: begin
          if (!ext_mode && req_rise) begin
            state_nxt = ssr_pkg::SEQ_EXPOSE;
            seq_cnt_nxt = exp_cfg;
            frames_left_nxt = frames_req;
          end else if (ext_mode && req_rise) begin
            state_nxt = ssr_pkg::SEQ_FOT;
            seq_cnt_nxt = 24'(FOT_CYC - 1);
          end else if (ext_mode && int_rise) begin
            state_nxt = ssr_pkg::SEQ_EXPOSE;
          end
        end
        ssr_pkg::SEQ_EXPOSE: begin
          if (ext_mode) begin
            if (req_rise) begin
              state_nxt = ssr_pkg::SEQ_FOT;
              seq_cnt_nxt = 24'(FOT_CYC - 1);
            end
          end else if (seq_cnt_r == 24'h000000) begin
            state_nxt = ssr_pkg::SEQ_FOT;
            seq_cnt_nxt = 24'(FOT_CYC - 1);
          end else if (tick) begin
            seq_cnt_nxt = seq_cnt_r - 24'h000001;
          end
        end
        ssr_pkg::SEQ_FOT: begin
          if (ext_mode && req_rise) begin
            seq_cnt_nxt = 24'(FOT_CYC - 1);
          end else if (seq_cnt_r == 24'h000000) begin
            state_nxt = ssr_pkg::SEQ_READOUT;
            seq_cnt_nxt = 24'(READOUT_CYC - 1);
          end else begin
            seq_cnt_nxt = seq_cnt_r - 24'h000001;
          end
        end
        ssr_pkg::SEQ_READOUT: begin
          if (ext_mode && req_rise) begin
            state_nxt = ssr_pkg::SEQ_FOT;
            seq_cnt_nxt = 24'(FOT_CYC - 1);
          end else if (!readout_done) begin
            seq_cnt_nxt = seq_cnt_r - 24'h000001;
          end else if (!ext_mode && frames_left_r > 16'h0001) begin
            state_nxt = ssr_pkg::SEQ_EXPOSE;
            seq_cnt_nxt = exp_cfg;
            frames_left_nxt = frames_left_r - 16'h0001;
          end else begin
            state_nxt = ssr_pkg::SEQ_IDLE;
            frames_left_nxt = 16'h0000;
          end
        end
        default: begin
          state_nxt = ssr_pkg::SEQ_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      state_r <= ssr_pkg::SEQ_IDLE;
      seq_cnt_r <= 24'h000000;
      frames_left_r <= 16'h0000;
    end else begin
      state_r <= state_nxt;
      seq_cnt_r <= seq_cnt_nxt;
      frames_left_r <= frames_left_nxt;
    end
  end

  // Status outputs; each is a decode of the sequencer state
  assign o_exposing = (state_r == ssr_pkg::SEQ_EXPOSE);
  assign o_frame_overhead_time = (state_r == ssr_pkg::SEQ_FOT);
  assign o_readout = (state_r == ssr_pkg::SEQ_READOUT);

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  a_ro_write_drop: assert property (
    cmd_end && is_wr_r && is_read_only(addr_r) |=> $stable(mem_r[addr_r]))
    else $error("write reached a read-only register");
  a_read_msb_launch: assert property (
    addr_last |=> o_spi_out == $past(rd_value[7]))
    else $error("read MSB not launched after address LSB");
  a_read_shift_order: assert property (
    rd_shift |=> o_spi_out == $past(rd_sh_r[6]))
    else $error("read data not shifted MSB first");
  a_rise_capture_bit: assert property (
    en_lv && sclk_rise && bit_cnt_r < `SSR_CMD_BITS |=> bit_cnt_r == $past(bit_cnt_r) + 5'h01)
    else $error("rising edge did not capture a bit");
  a_write_commit_data: assert property (
    wr_en |=> mem_r[$past(addr_r)] == $past(wdata_r))
    else $error("write data not stored");
  a_temp_read_low: assert property (
    addr_last && addr_full == `SSR_OFF_TEMP_LO |=> rd_sh_r == $past(i_temperature[7:0]))
    else $error("temperature low byte not loaded");
  a_reset_ext_clear: assert property (
    $fell(i_rst) |-> !ext_mode && !gate && frames_cfg == 16'h0000)
    else $error("register not at default after reset");
  a_int_expose_start: assert property (
    state_r == ssr_pkg::SEQ_IDLE && !ext_mode && !gate && req_rise
    |=> state_r == ssr_pkg::SEQ_EXPOSE)
    else $error("internal request did not start exposure");
  a_ext_fot_start: assert property (
    ext_mode && !gate && req_rise |=> state_r == ssr_pkg::SEQ_FOT)
    else $error("external request did not start overhead time");
  a_frames_repeat: assert property (
    !gate && !ext_mode && state_r == ssr_pkg::SEQ_READOUT && readout_done
    && frames_left_r > 16'h0001 |=> state_r == ssr_pkg::SEQ_EXPOSE)
    else $error("next frame not started");
  a_burst_rearm: assert property (
    en_lv && cmd_end |=> bit_cnt_r == 5'h00)
    else $error("burst did not re-arm for the next command");
endmodule : ssr_top

// file: tb/ssr_host_model.sv
// Behavioural serial bus master that stands in for the host controller
`timescale 1ns/10ps
module ssr_host_model (
  input wire logic i_clk_sys,
  input wire logic i_spi_out,
  output logic o_spi_en,
  output logic o_spi_clk,
  output logic o_spi_in
);
  initial begin
    o_spi_en = 1'b0;
    o_spi_clk = 1'b0;
    o_spi_in = 1'b1;
  end

  // 400 ns serial period is eight system cycles
  task automatic half_clk();
    repeat (4) @(posedge i_clk_sys);
  endtask : half_clk

  // One command; select stays up when hold_en is set so the next one bursts
  task automatic xfer(input logic wr, input logic [6:0] addr, input logic [7:0] wdata,
                      input logic hold_en, output logic [7:0] rdata);
    logic [15:0] bits;
    bits = {wr, addr, wdata};
    rdata = 8'h00;
    @(posedge i_clk_sys);
    o_spi_en <= 1'b1;
    for (int i = 15; i >= 0; i--) begin
      o_spi_in <= bits[i];
      half_clk();
      // Read bits are taken as our clock rises
      if (i < 8) rdata[i] = i_spi_out;
      o_spi_clk <= 1'b1;
      half_clk();
      o_spi_clk <= 1'b0;
    end
    // Released data line does not keep the last value
    o_spi_in <= ~bits[0];
    half_clk();
    half_clk();
    // Deselect lasts long enough to pass the port's synchroniser
    if (!hold_en) begin
      o_spi_en <= 1'b0;
      half_clk();
    end
  endtask : xfer
endmodule : ssr_host_model

// file: tb/ssr_top_test.sv
// Self-checking bench for the serial register port and sequencer
`timescale 1ns/10ps
module ssr_top_test;
  logic i_clk_sys, i_rst, i_spi_en, i_spi_clk, i_spi_in, o_spi_out, i_frame_req, i_int_req;
  logic o_exposing, o_frame_overhead_time, o_readout, o_clock_gated;
  logic [15:0] i_temperature;
  logic [7:0] o_imm_ctrl, rd;
  int fails, comparisons, ex, fr, rr;

  ssr_top #(.EXP_TICK_CYC(2), .FOT_CYC(3), .READOUT_CYC(5)) ssr_top_inst (
    .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_spi_en(i_spi_en), .i_spi_clk(i_spi_clk),
    .i_spi_in(i_spi_in), .o_spi_out(o_spi_out), .i_frame_req(i_frame_req),
    .i_int_req(i_int_req), .i_temperature(i_temperature), .o_exposing(o_exposing),
    .o_frame_overhead_time(o_frame_overhead_time), .o_readout(o_readout),
    .o_clock_gated(o_clock_gated), .o_imm_ctrl(o_imm_ctrl));

  ssr_host_model ssr_host_model_inst (.i_clk_sys(i_clk_sys), .i_spi_out(o_spi_out),
    .o_spi_en(i_spi_en), .o_spi_clk(i_spi_clk), .o_spi_in(i_spi_in));

  initial begin
    i_clk_sys = 1'b0;
    forever #25 i_clk_sys = ~i_clk_sys;
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic wr(input logic [6:0] a, input logic [7:0] d, input logic hold = 1'b0);
    ssr_host_model_inst.xfer(1'b1, a, d, hold, rd);
  endtask : wr

  task automatic rd_chk(input logic [6:0] a, input logic [7:0] e, input logic hold = 1'b0);
    ssr_host_model_inst.xfer(1'b0, a, 8'h00, hold, rd);
    check({8'h00, rd}, {8'h00, e});
  endtask : rd_chk

  // Counts exposing cycles and rises of overhead and read-out over n cycles
  task automatic watch(input int n);
    logic pf, pr;
    ex = 0;
    fr = 0;
    rr = 0;
    pf = o_frame_overhead_time;
    pr = o_readout;
    repeat (n) begin
      @(posedge i_clk_sys);
      #1;
      ex += int'(o_exposing === 1'b1);
      fr += int'(o_frame_overhead_time === 1'b1 && pf !== 1'b1);
      rr += int'(o_readout === 1'b1 && pr !== 1'b1);
      pf = o_frame_overhead_time;
      pr = o_readout;
    end
    // Hand back on an edge so the caller drives inputs there
    @(posedge i_clk_sys);
  endtask : watch

  task automatic test_reset();
    rd_chk(7'h28, 8'h00);
    rd_chk(7'h7B, 8'h00);
    wr(7'h36, 8'h55);
    rd_chk(7'h36, 8'h55);
    @(posedge i_clk_sys);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    repeat (6) @(posedge i_clk_sys);
    rd_chk(7'h36, 8'h00);
    rd_chk(7'h37, 8'h00);
  endtask : test_reset

  task automatic test_burst();
    wr(7'h38, 8'hA5, 1'b1);
    wr(7'h39, 8'h3C, 1'b1);
    rd_chk(7'h38, 8'hA5, 1'b1);
    rd_chk(7'h39, 8'h3C);
    check({8'h00, o_imm_ctrl}, 16'h0099);
  endtask : test_burst

  task automatic test_temperature();
    i_temperature <= 16'hBEEF;
    rd_chk(7'h58, 8'hEF);
    rd_chk(7'h59, 8'hBE);
    wr(7'h58, 8'h00);
    wr(7'h59, 8'h11);
    rd_chk(7'h58, 8'hEF);
    rd_chk(7'h59, 8'hBE);
  endtask : test_temperature

  task automatic test_gating();
    wr(7'h7B, 8'h01);
    check({15'h0000, o_clock_gated}, 16'h0001);
    // Settling shortened: the model has no analog settling to wait for
    repeat (20) @(posedge i_clk_sys);
    i_frame_req <= 1'b1;
    watch(40);
    check(16'(ex + fr), 16'h0000);
    i_frame_req <= 1'b0;
    wr(7'h7B, 8'h00);
    check({15'h0000, o_clock_gated}, 16'h0000);
  endtask : test_gating

  task automatic test_internal();
    wr(7'h29, 8'h02);
    wr(7'h2A, 8'h00);
    wr(7'h2B, 8'h00);
    wr(7'h36, 8'h02);
    wr(7'h37, 8'h01);
    i_frame_req <= 1'b1;
    // Short enough that the first overhead rise falls in the long watch
    watch(6);
    check(16'(ex > 0), 16'h0001);
    i_frame_req <= 1'b0;
    watch(4000);
    check(16'(fr), 16'h0102);
    check(16'(rr), 16'h0102);
  endtask : test_internal

  task automatic test_external();
    wr(7'h36, 8'h01);
    wr(7'h37, 8'h00);
    wr(7'h28, 8'h01);
    i_int_req <= 1'b1;
    watch(10);
    watch(30);
    check(16'(ex), 16'h001E);
    // Status register shows the exposure state code in its low bits
    rd_chk(7'h5A, 8'h01);
    i_frame_req <= 1'b1;
    watch(30);
    check(16'(fr), 16'h0001);
    check(16'(rr), 16'h0001);
    check({14'h0000, o_exposing, o_readout}, 16'h0000);
    i_int_req <= 1'b0;
    i_frame_req <= 1'b0;
    wr(7'h28, 8'h00);
  endtask : test_external

  task automatic complete_run();
    $display("fails=%0d comparisons=%0d", fails, comparisons);
    if (fails == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : complete_run

  initial begin
    #2000000;
    fails++;
    complete_run();
  end

  initial begin
    i_rst = 1'b1;
    i_frame_req = 1'b0;
    i_int_req = 1'b0;
    i_temperature = 16'h0000;
    repeat (2) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    repeat (6) @(posedge i_clk_sys);
    test_reset();
    test_burst();
    test_temperature();
    test_gating();
    test_internal();
    test_external();
    complete_run();
  end
endmodule : ssr_top_test
